// >>> design/cds_scanner.sv
// Multiplexed display scanner for an eight-digit counter result.
`default_nettype none
module cds_scanner #(
  parameter int unsigned MEAS_FRAMES = cds_pkg::CDS_MEAS_FRAMES
) (
  // Clock and reset
  input  wire logic               ref_clk,
  input  wire logic               resetn,
  // Timebase, one pulse per oscillator cycle
  input  wire logic               osc_tick,
  // Mode selection and result
  input  wire cds_pkg::cds_ctrl_t ctrl,
  input  wire cds_pkg::cds_value_t value,
  // Display drive, common cathode
  output logic              [7:0] digit_on,
  output logic              [7:0] seg,
  // Measurement pacing
  output logic                    meas_tick
);

  if (MEAS_FRAMES < 1 || MEAS_FRAMES > 127) begin : g_bad_frames
    $error("MEAS_FRAMES must lie between 1 and 127");
  end

  // Digit is lit unless it is a leading zero left of the stop digit.
  function automatic logic digit_shown(input logic [31:0] bcd, input logic [2:0] stop,
                                       input logic [2:0] idx);
    logic upper_zero;
    upper_zero = 1'b1;
    for (int i = 0; i < cds_pkg::CDS_DIGITS; i++) begin
      if (3'(i) >= idx && bcd[4*i +: 4] != cds_pkg::CDS_BCD_ZERO) begin
        upper_zero = 1'b0;
      end
    end
    return !upper_zero || idx <= stop;
  endfunction : digit_shown

  logic [3:0]          pre_cnt;
  logic [7:0]          slot_cnt;
  logic [2:0]          digit_idx;
  logic [6:0]          frame_cnt;
  cds_pkg::cds_phase_t phase;
  logic [3:0]          next_pre_cnt;
  logic [7:0]          next_slot_cnt;
  logic [2:0]          next_digit_idx;
  logic [6:0]          next_frame_cnt;
  cds_pkg::cds_phase_t next_phase;
  logic                next_meas_tick;
  logic                us_tick;
  logic [7:0]          next_digit_on;
  logic [7:0]          next_seg;
  logic [6:0]          dec_seg;
  logic [2:0]          lz_stop;

  // Timing chain: timebase to microseconds, to slots, to frames, to measurements.
  always_comb begin
    us_tick        = osc_tick && (ctrl.mode_1mhz || pre_cnt == cds_pkg::CDS_PRE_LAST);
    next_pre_cnt   = pre_cnt;
    next_slot_cnt  = slot_cnt;
    next_digit_idx = digit_idx;
    next_frame_cnt = frame_cnt;
    next_meas_tick = 1'b0;
    if (osc_tick) begin
      next_pre_cnt = us_tick ? cds_pkg::CDS_PRE_RST : pre_cnt + 4'h1;
    end
    if (us_tick) begin
      if (slot_cnt == cds_pkg::CDS_SLOT_LAST) begin
        next_slot_cnt  = cds_pkg::CDS_SLOT_RST;
        next_digit_idx = digit_idx + 3'h1;
        if (digit_idx == cds_pkg::CDS_DIGIT_LAST) begin
          if (frame_cnt == 7'(MEAS_FRAMES - 1)) begin
            next_frame_cnt = cds_pkg::CDS_FRAME_RST;
            next_meas_tick = 1'b1;
          end else begin
            next_frame_cnt = frame_cnt + 7'h01;
          end
        end
      end else begin
        next_slot_cnt = slot_cnt + 8'h01;
      end
    end
    next_phase = (next_slot_cnt < cds_pkg::CDS_BLANK_END) ? cds_pkg::CDS_BLANK : cds_pkg::CDS_SHOW;
  end

  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      pre_cnt   <= cds_pkg::CDS_PRE_RST;
      slot_cnt  <= cds_pkg::CDS_SLOT_RST;
      digit_idx <= cds_pkg::CDS_DIGIT_RST;
      frame_cnt <= cds_pkg::CDS_FRAME_RST;
      phase     <= cds_pkg::CDS_BLANK;
      meas_tick <= 1'b0;
    end else begin
      pre_cnt   <= next_pre_cnt;
      slot_cnt  <= next_slot_cnt;
      digit_idx <= next_digit_idx;
      frame_cnt <= next_frame_cnt;
      phase     <= next_phase;
      meas_tick <= next_meas_tick;
    end
  end

  cds_seg_decode u_decode (
    .bcd (value.bcd[4*digit_idx +: 4]),
    .seg (dec_seg)
  );

  // Drive pattern for the current slot; outputs follow the state by one clock.
  always_comb begin
    lz_stop       = value.dp_en ? value.dp_digit : cds_pkg::CDS_DIGIT_RST;
    next_digit_on = cds_pkg::CDS_DARK;
    next_seg      = cds_pkg::CDS_DARK;
    if (ctrl.off || phase == cds_pkg::CDS_BLANK) begin
      next_digit_on = cds_pkg::CDS_DARK;
      next_seg      = cds_pkg::CDS_DARK;
    end else if (ctrl.test) begin
      next_digit_on = 8'h01 << digit_idx;
      next_seg      = cds_pkg::CDS_SEG_TEST;
    end else if (value.overflow || digit_shown(value.bcd, lz_stop, digit_idx)) begin
      next_digit_on = 8'h01 << digit_idx;
      next_seg      = {(value.dp_en && digit_idx == value.dp_digit)
                       || (value.overflow && digit_idx == cds_pkg::CDS_OVF_DIGIT), dec_seg};
    end
  end

  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      digit_on <= cds_pkg::CDS_DARK;
      seg      <= cds_pkg::CDS_DARK;
    end else begin
      digit_on <= next_digit_on;
      seg      <= next_seg;
    end
  end

  // Checks.
  chk_one_digit: assert property (@(posedge ref_clk) disable iff (!resetn)
    $onehot0(digit_on)) else $error("more than one digit driven");

  chk_gap_dark: assert property (@(posedge ref_clk) disable iff (!resetn)
    phase == cds_pkg::CDS_BLANK |=> digit_on == 8'h00 && seg == 8'h00)
    else $error("output lit during interdigit gap");

  chk_slot_bound: assert property (@(posedge ref_clk) disable iff (!resetn)
    us_tick && slot_cnt == cds_pkg::CDS_SLOT_LAST
    |=> slot_cnt == cds_pkg::CDS_SLOT_RST && phase == cds_pkg::CDS_BLANK)
    else $error("slot did not wrap after 250 us");

  chk_gap_end: assert property (@(posedge ref_clk) disable iff (!resetn)
    us_tick && slot_cnt == cds_pkg::CDS_BLANK_END - 8'h01 |=> phase == cds_pkg::CDS_SHOW)
    else $error("gap not 6 us long");

  chk_digit_order: assert property (@(posedge ref_clk) disable iff (!resetn)
    us_tick && slot_cnt == cds_pkg::CDS_SLOT_LAST |=> digit_idx == $past(digit_idx) + 3'h1)
    else $error("digit order broken");

  chk_meas_frame: assert property (@(posedge ref_clk) disable iff (!resetn)
    meas_tick |-> $past(digit_idx) == cds_pkg::CDS_DIGIT_LAST && $past(slot_cnt) == cds_pkg::CDS_SLOT_LAST
    && frame_cnt == cds_pkg::CDS_FRAME_RST)
    else $error("measurement tick off frame boundary");

  chk_prescale: assert property (@(posedge ref_clk) disable iff (!resetn)
    osc_tick && !ctrl.mode_1mhz
    |=> pre_cnt == (($past(pre_cnt) == cds_pkg::CDS_PRE_LAST) ? cds_pkg::CDS_PRE_RST : $past(pre_cnt) + 4'h1))
    else $error("10 MHz mode prescale not ten");

  chk_test_eights: assert property (@(posedge ref_clk) disable iff (!resetn)
    phase == cds_pkg::CDS_SHOW && ctrl.test && !ctrl.off |=> seg == 8'hFF && digit_on != 8'h00)
    else $error("display test pattern missing");

  chk_off_dark: assert property (@(posedge ref_clk) disable iff (!resetn)
    ctrl.off |=> digit_on == 8'h00 && seg == 8'h00)
    else $error("display off not dark");

  chk_ovf_point: assert property (@(posedge ref_clk) disable iff (!resetn)
    phase == cds_pkg::CDS_SHOW && !ctrl.off && value.overflow && digit_idx == 3'd7 |=> seg[7] && digit_on[7])
    else $error("overflow point not lit");

  chk_ovf_noblank: assert property (@(posedge ref_clk) disable iff (!resetn)
    phase == cds_pkg::CDS_SHOW && !ctrl.off && value.overflow |=> digit_on != 8'h00)
    else $error("digit blanked during overflow");

  chk_lsd_shown: assert property (@(posedge ref_clk) disable iff (!resetn)
    phase == cds_pkg::CDS_SHOW && !ctrl.off && digit_idx == 3'd0 |=> digit_on == 8'h01)
    else $error("least significant digit not shown");

  chk_lead_blank: assert property (@(posedge ref_clk) disable iff (!resetn)
    phase == cds_pkg::CDS_SHOW && !ctrl.off && !ctrl.test && !value.overflow
    && !digit_shown(value.bcd, lz_stop, digit_idx) |=> digit_on == 8'h00)
    else $error("leading zero not blanked");

  chk_right_shown: assert property (@(posedge ref_clk) disable iff (!resetn)
    phase == cds_pkg::CDS_SHOW && !ctrl.off && value.dp_en && digit_idx <= value.dp_digit
    |=> digit_on != 8'h00)
    else $error("digit right of point blanked");

endmodule : cds_scanner
`default_nettype wire

// >>> inc/cds_pkg.sv
// Shared constants and types of the counter display scanner.
`default_nettype none
package cds_pkg;
  // Digit count of the display, digit 1 (index 0) is the least significant.
  localparam int unsigned CDS_DIGITS      = 8;
  // Slot timing in microseconds of timebase time.
  localparam int unsigned CDS_BLANK_US    = 6;
  localparam int unsigned CDS_DIGIT_US    = 244;
  localparam int unsigned CDS_SLOT_US     = CDS_BLANK_US + CDS_DIGIT_US;
  // Timebase ticks per microsecond in 10 MHz mode; 1 MHz mode uses one tick per microsecond.
  localparam int unsigned CDS_TICKS_PER_US_10M = 10;
  // Time between measurements in microseconds of timebase time.
  localparam int unsigned CDS_MEAS_US     = 200000;
  localparam int unsigned CDS_FRAME_US    = CDS_SLOT_US * CDS_DIGITS;
  localparam int unsigned CDS_MEAS_FRAMES = CDS_MEAS_US / CDS_FRAME_US;
  // Counter limits at register width.
  localparam logic [3:0] CDS_PRE_LAST   = 4'(CDS_TICKS_PER_US_10M - 1);
  localparam logic [7:0] CDS_SLOT_LAST  = 8'(CDS_SLOT_US - 1);
  localparam logic [7:0] CDS_BLANK_END  = 8'(CDS_BLANK_US);
  localparam logic [2:0] CDS_DIGIT_LAST = 3'(CDS_DIGITS - 1);
  localparam logic [2:0] CDS_OVF_DIGIT  = 3'(CDS_DIGITS - 1);
  // Reset values and fixed patterns.
  localparam logic [3:0] CDS_PRE_RST    = 4'h0;
  localparam logic [7:0] CDS_SLOT_RST   = 8'h00;
  localparam logic [2:0] CDS_DIGIT_RST  = 3'h0;
  localparam logic [6:0] CDS_FRAME_RST  = 7'h00;
  localparam logic [7:0] CDS_DARK       = 8'h00;
  localparam logic [7:0] CDS_SEG_TEST   = 8'hFF;
  localparam logic [3:0] CDS_BCD_ZERO   = 4'h0;

  // Latched result to show.
  typedef struct packed {
    logic [31:0] bcd;
    logic        dp_en;
    logic [2:0]  dp_digit;
    logic        overflow;
  } cds_value_t;

  // Static mode selection.
  typedef struct packed {
    logic test;
    logic off;
    logic mode_1mhz;
  } cds_ctrl_t;

  typedef enum logic {
    CDS_BLANK,
    CDS_SHOW
  } cds_phase_t;
endpackage : cds_pkg
`default_nettype wire

// >>> design/cds_seg_decode.sv
// BCD to seven-segment decoder, segments ordered g f e d c b a.
`default_nettype none
module cds_seg_decode (
  // Digit value
  input  wire logic [3:0] bcd,
  // Segment pattern
  output logic      [6:0] seg
);
  always_comb begin
    unique case (bcd)
      4'h0:    seg = 7'h3F;
      4'h1:    seg = 7'h06;
      4'h2:    seg = 7'h5B;
      4'h3:    seg = 7'h4F;
      4'h4:    seg = 7'h66;
      4'h5:    seg = 7'h6D;
      4'h6:    seg = 7'h7D;
      4'h7:    seg = 7'h07;
      4'h8:    seg = 7'h7F;
      4'h9:    seg = 7'h6F;
      // Codes above nine are not decimal and stay dark.
      default: seg = 7'h00;
    endcase
  end
endmodule : cds_seg_decode
`default_nettype wire

// >>> dv/cds_led_model.sv
// Common cathode LED display model that records the segments each digit showed.
`default_nettype none
module cds_led_model (
  // Clock and reset
  input  wire logic       ref_clk,
  input  wire logic       resetn,
  // Display drive and record clear
  input  wire logic [7:0] digit_on,
  input  wire logic [7:0] seg,
  input  wire logic       clear,
  // Recorded segments and fault count
  output logic      [7:0] shown [8],
  output int              bad
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [2:0] last;

  // A segment only lights while its cathode is driven, so patterns are gathered per lit digit.
  always @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      bad <= 0;
      last <= 3'h0;
      shown <= '{default: 8'h00};
    end else if (clear) begin
      shown <= '{default: 8'h00};
    end else if (digit_on == 8'h00) begin
      if (seg != 8'h00) bad <= bad + 1;
    end else begin
      for (int i = 0; i < 8; i++) begin
        if (digit_on[i]) begin
          shown[i] <= shown[i] | seg;
          // Leading digits may stay dark, so a wrap to digit 1 is allowed from any digit.
          if (!$onehot(digit_on) || !(i[2:0] == last || i[2:0] == last + 3'h1 || i == 0)) bad <= bad + 1;
          last <= i[2:0];
        end
      end
    end
  end
endmodule : cds_led_model
`default_nettype wire

// >>> dv/testbench.sv
// Self-checking testbench of the counter display scanner.
`default_nettype none
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  logic                ref_clk = 1'b0;
  logic                resetn = 1'b0;
  logic                osc_tick = 1'b0;
  logic                clear = 1'b0;
  cds_pkg::cds_ctrl_t  ctrl = 3'h1;
  cds_pkg::cds_value_t value = '0;
  logic          [7:0] digit_on;
  logic          [7:0] seg;
  logic                meas_tick;
  logic          [7:0] shown [8];
  int                  bad;
  int                  err_total = 0;
  int                  n_compared = 0;
  int                  cycles = 0;
  int                  div = 1;
  int                  phase = 0;

  cds_scanner #(.MEAS_FRAMES(1)) dut (.ref_clk(ref_clk), .resetn(resetn), .osc_tick(osc_tick), .ctrl(ctrl),
    .value(value), .digit_on(digit_on), .seg(seg), .meas_tick(meas_tick));
  cds_led_model disp (.ref_clk(ref_clk), .resetn(resetn), .digit_on(digit_on), .seg(seg), .clear(clear),
    .shown(shown), .bad(bad));

  always #2 ref_clk = ~ref_clk;

  // The timebase is the bench clock divided by div, so a slower crystal is one larger divisor.
  always @(negedge ref_clk) begin
    phase <= (phase + 1) % div;
    osc_tick <= (phase == 0);
    cycles <= cycles + 1;
    if (cycles == 100000) begin
      err_total++;
      complete_run();
    end
  end

  task automatic cmp8(input string nm, input logic [7:0] e, input logic [7:0] g);
    n_compared++;
    if (g !== e) begin
      err_total++;
      $display("MISMATCH %s expected %h seen %h", nm, e, g);
    end
  endtask : cmp8

  task automatic cmp_n(input string nm, input int e, input int g);
    n_compared++;
    if (g != e) begin
      err_total++;
      $display("MISMATCH %s expected %0d seen %0d", nm, e, g);
    end
  endtask : cmp_n

  // Shows one result for a whole scan and compares each digit, digit 1 in the low byte.
  task automatic t_scan(input logic [31:0] bcd, input logic dpe, input logic [2:0] dpd, input logic ov,
                        input logic tst, input logic off, input logic [63:0] exp);
    value = {bcd, dpe, dpd, ov};
    ctrl = {tst, off, 1'b1};
    clear = 1'b1;
    @(negedge ref_clk);
    clear = 1'b0;
    repeat (2050) @(negedge ref_clk);
    for (int i = 0; i < 8; i++) cmp8("digit segments", exp[i*8+:8], shown[i]);
  endtask : t_scan

  // Measures frame, lit time and gap in bench cycles for one timebase setting.
  task automatic t_time(input logic m1, input int d, input int us);
    int hi;
    int lo;
    int fr;
    hi = 0;
    lo = 0;
    fr = 0;
    value = {32'h0000_0000, 1'b0, 3'h0, 1'b1};
    ctrl = {2'h0, m1};
    div = d;
    do @(negedge ref_clk); while (meas_tick !== 1'b1);
    do begin @(negedge ref_clk); fr++; end while (meas_tick !== 1'b1);
    while (digit_on[0] !== 1'b1) @(negedge ref_clk);
    while (digit_on[0] === 1'b1) begin hi++; @(negedge ref_clk); end
    while (digit_on === 8'h00) begin lo++; @(negedge ref_clk); end
    cmp_n("frame cycles", 2000 * us * d, fr);
    cmp_n("lit cycles", 244 * us * d, hi);
    cmp_n("gap cycles", 6 * us * d, lo);
    cmp8("next digit", 8'h02, digit_on);
  endtask : t_time

  task automatic complete_run;
    $display("compared %0d mismatches %0d", n_compared, err_total);
    if (err_total == 0 && n_compared > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : complete_run

  initial begin
    repeat (8) @(negedge ref_clk);
    resetn = 1'b1;
    t_scan(32'h0000_1203, 1'b0, 3'h0, 1'b0, 1'b0, 1'b0, 64'h0000_0000_065B_3F4F);
    t_scan(32'h0000_0000, 1'b1, 3'h3, 1'b0, 1'b0, 1'b0, 64'h0000_0000_BF3F_3F3F);
    t_scan(32'h0000_0005, 1'b0, 3'h0, 1'b1, 1'b0, 1'b0, 64'hBF3F_3F3F_3F3F_3F6D);
    t_scan(32'h0000_0000, 1'b0, 3'h0, 1'b0, 1'b1, 1'b0, 64'hFFFF_FFFF_FFFF_FFFF);
    t_scan(32'h0000_0000, 1'b0, 3'h0, 1'b0, 1'b1, 1'b1, 64'h0000_0000_0000_0000);
    t_time(1'b0, 1, 10);
    t_time(1'b1, 4, 1);
    cmp_n("display faults", 0, bad);
    complete_run();
  end
endmodule : testbench
`default_nettype wire
